// ---- hdl/bkpt_trigger.sv ----
// Level-one breakpoint trigger: PC, data-address and data-value comparators.
// Assumes the core presents one-cycle pc_valid and bus_valid strobes on pclk,
// and that debug-register writes arrive on the link or from the supervisor port.
// Function
// RULE_01 - Data enables gate data-value comparison
// RULE_02 - Seven enables: longword, halfwords, four bytes
// RULE_03 - Data invert flips every data comparator
// RULE_04 - Address enable field; zero disables
// RULE_05 - Top bit: address outside range
// RULE_06 - Middle bit: address inside inclusive range
// RULE_07 - Low bit: address equals low bound
// RULE_08 - PC enable and PC invert bits
// RULE_09 - First PC breakpoint compared under mask
// RULE_10 - Mask bits 31..1 affect first only
// RULE_11 - Other three match only when valid
// RULE_12 - Software writes bit 0 of first zero
// RULE_13 - Software zeroes PC address top byte
// RULE_14 - Mask undefined after reset; initialise first
// RULE_15 - Writable by instruction and debug port
// RULE_16 - Combine bit selects AND or OR
// RULE_17 - Global enable suppresses all triggers
// RULE_18 - One-cycle pulse per qualified transfer
`timescale 1ns/1ps
`include "bkpt_params.svh"
module bkpt_trigger (
    input wire logic pclk,
    input wire logic presetn,
    bkpt_link_if.device link,
    input wire logic sup_wr,
    input wire logic [2:0] sup_sel,
    input wire logic [31:0] sup_data,
    input wire logic pc_valid,
    input wire logic [31:0] pc,
    input wire logic bus_valid,
    input wire logic [31:0] bus_addr,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_data,
    input wire logic [31:0] data_match_value,
    output logic trigger_pulse
);
    import bkpt_pkg::*;

    // Returns one when a write strobe addresses the register with the given code.
    function automatic logic sel_hit(input logic strobe, input dreg_sel_type sel,
                                     input dreg_sel_type code);
        sel_hit = strobe & (sel == code);
    endfunction : sel_hit

    word_type trigger_definition_ff;
    word_type pc_breakpoint_masked_ff;
    word_type pc_bkpt_ff [1:3];
    word_type pc_breakpoint_mask_ff;
    word_type address_low_bound_ff;
    word_type address_high_bound_ff;
    logic trigger_ff;
    word_type match_pc_ff;
    logic pc_hit_ff;

    // RULE_15 both writers
    wire wr_en = link.dreg_wr | sup_wr;
    wire dreg_sel_type wr_sel = link.dreg_wr ? link.dreg_sel : sup_sel;
    wire word_type wr_data = link.dreg_wr ? link.dreg_data : sup_data;

    wire logic [6:0] lvl1_data_enable =
        trigger_definition_ff[`TDR_DATA_EN_HI:`TDR_DATA_EN_LO];
    wire lvl1_data_invert = trigger_definition_ff[`TDR_DATA_INV];
    wire logic [2:0] lvl1_address_enable =
        trigger_definition_ff[`TDR_ADDR_EN_HI:`TDR_ADDR_EN_LO];
    wire lvl1_pc_enable = trigger_definition_ff[`TDR_PC_EN];
    wire lvl1_pc_invert = trigger_definition_ff[`TDR_PC_INV];
    wire lvl1_combine_select = trigger_definition_ff[`TDR_COMBINE];
    wire lvl1_global_enable = trigger_definition_ff[`TDR_GLOBAL_EN];

    // RULE_09 masked compare
    wire pc0_hit =
        ((pc ^ pc_breakpoint_masked_ff) & ~{pc_breakpoint_mask_ff[31:1], 1'b0}) == `ZERO_WORD;
    logic [3:1] pcn_hit;
    genvar gi;
    generate
        for (gi = 1; gi <= 3; gi++) begin : g_pcn
            // RULE_11 valid qualified
            assign pcn_hit[gi] = pc_bkpt_ff[gi][0] & (pc[31:1] == pc_bkpt_ff[gi][31:1]);
        end
    endgenerate
    // RULE_08 enable and invert
    wire pc_cond = lvl1_pc_enable & ((pc0_hit | (|pcn_hit)) ^ lvl1_pc_invert);

    wire addr_ge = bus_addr >= address_low_bound_ff;
    wire addr_le = bus_addr <= address_high_bound_ff;
    // RULE_05 outside range
    wire addr_out = lvl1_address_enable[2] & ~(addr_ge & addr_le);
    // RULE_06 inclusive range
    wire addr_in = lvl1_address_enable[1] & addr_ge & addr_le;
    // RULE_07 equal low
    wire addr_eq = lvl1_address_enable[0] & (bus_addr == address_low_bound_ff);
    // RULE_04 field disables
    wire addr_cond = addr_out | addr_in | addr_eq;

    // Byte lanes of the data bus; lane_eq[0] is the low-order byte.
    wire logic [3:0] lane_eq;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_eq[gi] = bus_data[8*gi +: 8] == data_match_value[8*gi +: 8];
        end
    endgenerate
    // RULE_02 lane selection
    wire logic [6:0] cmp_raw = {&lane_eq, &lane_eq[1:0], &lane_eq[3:2],
                                lane_eq[0], lane_eq[1], lane_eq[2], lane_eq[3]};
    // RULE_03 invert comparators
    wire logic [6:0] cmp = cmp_raw ^ {7{lvl1_data_invert}};
    // RULE_01 enabled comparators
    wire data_any = |lvl1_data_enable;
    wire data_cond = ~data_any | (|(cmp & lvl1_data_enable));
    wire ad_cond = (addr_cond | (lvl1_address_enable == 3'b000 & data_any)) & data_cond
                   & ((lvl1_address_enable != 3'b000) | data_any) & bus_valid;

    // A PC hit is held until the next bus transfer so AND mode can pair them.
    wire pc_now = pc_valid & pc_cond;
    wire pc_term = pc_now | pc_hit_ff;
    // RULE_16 combine
    wire comb = lvl1_combine_select ? (pc_now | ad_cond) : (pc_term & ad_cond);
    // RULE_17 global enable
    wire nxt_trigger = lvl1_global_enable & comb;

    // One write strobe per register, decoded from the merged write port.
    wire wr_trigger = sel_hit(wr_en, wr_sel, `DREG_SEL_TRIGGER);
    wire wr_pc0 = sel_hit(wr_en, wr_sel, `DREG_SEL_PC0);
    wire wr_mask = sel_hit(wr_en, wr_sel, `DREG_SEL_MASK);
    wire wr_alow = sel_hit(wr_en, wr_sel, `DREG_SEL_ALOW);
    wire wr_ahigh = sel_hit(wr_en, wr_sel, `DREG_SEL_AHIGH);
    logic [3:1] wr_pcn;
    generate
        for (gi = 1; gi <= 3; gi++) begin : g_pcn_wr
            assign wr_pcn[gi] = sel_hit(wr_en, wr_sel, dreg_sel_type'(`DREG_SEL_PC0 + gi));
        end
    endgenerate

    // RULE_15 register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_definition_ff <= `ZERO_WORD;
        end else if (wr_trigger) begin
            trigger_definition_ff <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_breakpoint_masked_ff <= `ZERO_WORD;
        end else if (wr_pc0) begin
            pc_breakpoint_masked_ff <= wr_data;
        end
    end

    // Clearing the valid flags at reset keeps the three extra compares silent.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 1; i <= 3; i++) begin
                pc_bkpt_ff[i] <= `ZERO_WORD;
            end
        end else begin
            for (int i = 1; i <= 3; i++) begin
                if (wr_pcn[i]) begin
                    pc_bkpt_ff[i] <= wr_data;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_low_bound_ff <= `ZERO_WORD;
        end else if (wr_alow) begin
            address_low_bound_ff <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_high_bound_ff <= `ZERO_WORD;
        end else if (wr_ahigh) begin
            address_high_bound_ff <= wr_data;
        end
    end

    // RULE_14 mask has no reset
    always_ff @(posedge pclk) begin
        if (wr_mask) begin
            pc_breakpoint_mask_ff <= wr_data;
        end
    end

    // RULE_18 single-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_ff <= 1'b0;
            match_pc_ff <= `ZERO_WORD;
            pc_hit_ff <= 1'b0;
        end else begin
            trigger_ff <= nxt_trigger;
            pc_hit_ff <= bus_valid ? 1'b0 : pc_term;
            if (nxt_trigger) begin
                match_pc_ff <= pc;
            end
        end
    end

    assign trigger_pulse = trigger_ff;
    assign link.trigger = trigger_ff;
    assign link.match_pc = match_pc_ff;
endmodule : bkpt_trigger

// ---- hdl/bkpt_params.svh ----
// Constants of the level-one breakpoint trigger: register map and field positions.
// Assumes inclusion by bare name from both ends of the debug link.
`ifndef BKPT_PARAMS_SVH
`define BKPT_PARAMS_SVH

`define DREG_SEL_TRIGGER 3'h0
`define DREG_SEL_PC0 3'h1
`define DREG_SEL_PC1 3'h2
`define DREG_SEL_PC2 3'h3
`define DREG_SEL_PC3 3'h4
`define DREG_SEL_MASK 3'h5
`define DREG_SEL_ALOW 3'h6
`define DREG_SEL_AHIGH 3'h7

`define TDR_DATA_EN_HI 28
`define TDR_DATA_EN_LO 22
`define TDR_GLOBAL_EN 13
`define TDR_COMBINE 14
`define TDR_DATA_INV 5
`define TDR_ADDR_EN_HI 4
`define TDR_ADDR_EN_LO 2
`define TDR_PC_EN 1
`define TDR_PC_INV 0

`define APB_CTRL 12'h000
`define APB_DATA 12'h004
`define APB_STATUS 12'h008
`define APB_IRQ_STATUS 12'h00C
`define APB_IRQ_CLEAR 12'h010
`define APB_IRQ_ENABLE 12'h014
`define APB_MATCH 12'h018

`define CTRL_RESET 32'h0000_0000
`define ZERO_WORD 32'h0000_0000
`define PC_ADDR_MSB_MASK 32'hFF00_0000

`endif

// ---- hdl/bkpt_pkg.sv ----
// Types shared by the breakpoint trigger and its debug-port controller.
// Assumes bkpt_params.svh is on the include path.
package bkpt_pkg;
    typedef logic [2:0] dreg_sel_type;
    typedef logic [31:0] word_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } host_state_type;
endpackage : bkpt_pkg

// ---- hdl/bkpt_link_if.sv ----
// Link between the breakpoint trigger and the debug-port controller.
// Assumes one clock and one reset shared by both ends.
`timescale 1ns/1ps
interface bkpt_link_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic dreg_wr;
    bkpt_pkg::dreg_sel_type dreg_sel;
    bkpt_pkg::word_type dreg_data;
    logic trigger;
    bkpt_pkg::word_type match_pc;

    modport device (
        input dreg_wr,
        input dreg_sel,
        input dreg_data,
        output trigger,
        output match_pc
    );
    modport host (
        output dreg_wr,
        output dreg_sel,
        output dreg_data,
        input trigger,
        input match_pc
    );
endinterface : bkpt_link_if

// ---- hdl/bkpt_host.sv ----
// Debug-port controller: APB slave that writes debug registers over the link.
// Assumes the trigger end shares pclk and presetn.
`timescale 1ns/1ps
`include "bkpt_params.svh"
module bkpt_host (
    input wire logic pclk,
    input wire logic presetn,
    bkpt_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import bkpt_pkg::*;

    host_state_type state_ff;
    host_state_type nxt_state;
    logic [2:0] sel_ff;
    word_type data_ff;
    logic wr_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_enable_ff;
    word_type match_ff;
    word_type prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;

    wire apb_setup = psel & ~penable;
    wire wr_ctrl = apb_setup & pwrite & (paddr == `APB_CTRL);
    wire wr_data = apb_setup & pwrite & (paddr == `APB_DATA);
    wire wr_clr = apb_setup & pwrite & (paddr == `APB_IRQ_CLEAR);
    wire wr_ena = apb_setup & pwrite & (paddr == `APB_IRQ_ENABLE);
    wire busy = state_ff != ST_IDLE;
    wire mapped = (paddr == `APB_CTRL) | (paddr == `APB_DATA) | (paddr == `APB_STATUS)
                  | (paddr == `APB_IRQ_STATUS) | (paddr == `APB_IRQ_CLEAR)
                  | (paddr == `APB_IRQ_ENABLE) | (paddr == `APB_MATCH);
    // Writing CTRL while idle starts a debug-register write of DATA to the selected register.
    wire go = wr_ctrl & ~busy;
    wire logic [31:0] rd_mux =
        (paddr == `APB_CTRL) ? {29'h0000_0000, sel_ff} :
        (paddr == `APB_DATA) ? data_ff :
        (paddr == `APB_STATUS) ? {31'h0000_0000, busy} :
        (paddr == `APB_IRQ_STATUS) ? {30'h0000_0000, irq_status_ff} :
        (paddr == `APB_IRQ_ENABLE) ? {30'h0000_0000, irq_enable_ff} :
        (paddr == `APB_MATCH) ? match_ff : `ZERO_WORD;
    // Event 0 is a trigger pulse, event 1 a finished register write.
    wire logic [1:0] evt = {state_ff == ST_DONE, link.trigger};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (go) nxt_state = ST_SEND;
            ST_SEND: nxt_state = ST_DONE;
            ST_DONE: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            sel_ff <= 3'h0;
            data_ff <= `ZERO_WORD;
            wr_ff <= 1'b0;
            match_ff <= `ZERO_WORD;
        end else begin
            state_ff <= nxt_state;
            wr_ff <= go;
            if (go) sel_ff <= pwdata[2:0];
            // RULE_13 top byte passed on as software wrote it
            if (wr_data && !busy) data_ff <= pwdata;
            if (link.trigger) match_ff <= link.match_pc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= 2'h0;
            irq_enable_ff <= 2'h0;
            prdata_ff <= `ZERO_WORD;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle.
            irq_status_ff <= (irq_status_ff & ~(wr_clr ? pwdata[1:0] : 2'h0)) | evt;
            if (wr_ena) irq_enable_ff <= pwdata[1:0];
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & (~mapped | (wr_ctrl & busy));
            prdata_ff <= (apb_setup & ~pwrite) ? rd_mux : `ZERO_WORD;
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    // RULE_15 debug port write
    assign link.dreg_wr = wr_ff;
    assign link.dreg_sel = sel_ff;
    // RULE_12 software keeps bit 0 clear
    assign link.dreg_data = data_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
endmodule : bkpt_host

// ---- test/bkpt_link_sva.sv ----
// Checker on the link signals between the trigger end and the controller end.
// Assumes one clock and an asynchronous active-low reset shared by both ends.
`timescale 1ns/1ps
`include "bkpt_params.svh"
module bkpt_link_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dreg_wr,
    input wire bkpt_pkg::dreg_sel_type dreg_sel,
    input wire bkpt_pkg::word_type dreg_data,
    input wire logic trigger,
    input wire bkpt_pkg::word_type match_pc
);
    import bkpt_pkg::*;
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wr_gap; dreg_wr |=> !dreg_wr [*2]; endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("link writes too close");
    property p_pc0_even; dreg_wr && dreg_sel == `DREG_SEL_PC0 |-> !dreg_data[0]; endproperty
    a_pc0_even: assert property (p_pc0_even) else $error("odd pc0 address");
    property p_pc_top;
        dreg_wr && dreg_sel inside {[`DREG_SEL_PC0:`DREG_SEL_PC3]} |-> dreg_data[31:24] == 8'h00;
    endproperty
    a_pc_top: assert property (p_pc_top) else $error("pc address top byte set");
    property p_trig_gap; trigger |=> !trigger; endproperty
    a_trig_gap: assert property (p_trig_gap) else $error("trigger longer than a cycle");
    property p_match_cause; $changed(match_pc) |-> trigger; endproperty
    a_match_cause: assert property (p_match_cause) else $error("match pc moved alone");
    property p_reset_quiet; $rose(presetn) |-> !trigger && !dreg_wr; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("link busy after reset");
endmodule : bkpt_link_sva

// ---- test/level1_breakpoint_trigger_tb_top.sv ----
// Testbench: drives the trigger core ports and the APB side of the controller.
// Assumes the design files and bkpt_params.svh are compiled before it.
`timescale 1ns/1ps
`include "bkpt_params.svh"
module level1_breakpoint_trigger_tb_top;
    import bkpt_pkg::*;
    localparam word_type g_en = 32'h1 << `TDR_GLOBAL_EN;
    localparam word_type c_or = 32'h1 << `TDR_COMBINE;
    localparam word_type pc_en = 32'h1 << `TDR_PC_EN;
    localparam word_type pc_inv = 32'h1 << `TDR_PC_INV;
    localparam word_type eq = 32'h1 << `TDR_ADDR_EN_LO;
    localparam word_type d_inv = 32'h1 << `TDR_DATA_INV;
    localparam word_type adrs [4] = '{32'h0000_0100, 32'h0000_01FF, 32'h0000_0200, 32'h0000_00FF};
    localparam logic [3:0] amode [4] = '{4'h0, 4'h1, 4'h3, 4'hC};
    localparam word_type lane [7] = '{32'hFF00_0000, 32'h00FF_0000, 32'h0000_FF00,
        32'h0000_00FF, 32'hFFFF_0000, 32'h0000_FFFF, 32'hFFFF_FFFF};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic sup_wr, pc_valid, bus_valid, trigger_pulse;
    logic [11:0] paddr;
    logic [2:0] sup_sel;
    word_type pwdata, prdata, rd, sup_data, pc, bus_addr, bus_data, dmv;
    int error_cnt = 0;
    int compares = 0;
    bkpt_link_if bkpt_link_if_inst (.pclk(pclk), .presetn(presetn));
    bkpt_trigger bkpt_trigger_inst (.pclk(pclk), .presetn(presetn), .link(bkpt_link_if_inst),
        .sup_wr(sup_wr), .sup_sel(sup_sel), .sup_data(sup_data), .pc_valid(pc_valid), .pc(pc),
        .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_size(2'h2), .bus_data(bus_data),
        .data_match_value(dmv), .trigger_pulse(trigger_pulse));
    bkpt_host bkpt_host_inst (.pclk(pclk), .presetn(presetn), .link(bkpt_link_if_inst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    bkpt_link_sva bkpt_link_sva_inst (.pclk(pclk), .presetn(presetn),
        .dreg_wr(bkpt_link_if_inst.dreg_wr), .dreg_sel(bkpt_link_if_inst.dreg_sel),
        .dreg_data(bkpt_link_if_inst.dreg_data), .trigger(bkpt_link_if_inst.trigger),
        .match_pc(bkpt_link_if_inst.match_pc));
    task automatic chk(input word_type got, input word_type exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input word_type d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    // Debug-port write: data word, then select, then wait while busy.
    task automatic dw(input logic [2:0] s, input word_type d);
        apb(1'h1, `APB_DATA, d);
        apb(1'h1, `APB_CTRL, {29'h0, s});
        do apb(1'h0, `APB_STATUS, '0); while (rd[0] !== 1'h0);
    endtask : dw
    task automatic sw(input logic [2:0] s, input word_type d);
        sup_wr <= 1'h1;
        sup_sel <= s;
        sup_data <= d;
        @(posedge pclk);
        sup_wr <= 1'h0;
        @(posedge pclk);
    endtask : sw
    // A zero pc or address means that strobe stays low.
    task automatic ev(input word_type p, input word_type a, input word_type d, input logic e);
        logic got;
        pc_valid <= (p != 32'h0);
        bus_valid <= (a != 32'h0);
        pc <= p;
        bus_addr <= a;
        bus_data <= d;
        @(posedge pclk);
        pc_valid <= 1'h0;
        bus_valid <= 1'h0;
        got = 1'h0;
        repeat (3) begin
            @(posedge pclk);
            got = got | trigger_pulse;
        end
        chk({31'h0, got}, {31'h0, e});
    endtask : ev
    task automatic irq_is(input logic e);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_is
    task automatic t_pc;
        sw(`DREG_SEL_MASK, 32'h0000_0000);
        dw(`DREG_SEL_PC0, 32'h0000_1000);
        sw(`DREG_SEL_TRIGGER, g_en | c_or | pc_en);
        ev(32'h0000_1000, '0, '0, 1'h1);
        ev(32'h0000_1002, '0, '0, 1'h0);
        sw(`DREG_SEL_MASK, 32'h0000_0002);
        ev(32'h0000_1002, '0, '0, 1'h1);
        dw(`DREG_SEL_PC1, 32'h0000_2000);
        ev(32'h0000_2000, '0, '0, 1'h0);
        sw(`DREG_SEL_PC1, 32'h0000_2001);
        ev(32'h0000_2000, '0, '0, 1'h1);
        ev(32'h0000_2002, '0, '0, 1'h0);
        sw(`DREG_SEL_TRIGGER, g_en | c_or | pc_en | pc_inv);
        ev(32'h0000_3000, '0, '0, 1'h1);
        ev(32'h0000_1000, '0, '0, 1'h0);
        sw(`DREG_SEL_TRIGGER, c_or | pc_en);
        ev(32'h0000_1000, '0, '0, 1'h0);
        $display("pc test done");
    endtask : t_pc
    task automatic t_addr;
        dw(`DREG_SEL_ALOW, 32'h0000_0100);
        sw(`DREG_SEL_AHIGH, 32'h0000_01FF);
        for (int m = 0; m < 4; m++) begin
            sw(`DREG_SEL_TRIGGER, g_en | c_or | ((m == 0) ? '0 : (eq << (m - 1))));
            for (int k = 0; k < 4; k++) ev('0, adrs[k], '0, amode[m][k]);
        end
        $display("address test done");
    endtask : t_addr
    task automatic t_data;
        for (int b = 0; b < 7; b++) begin
            sw(`DREG_SEL_TRIGGER, g_en | c_or | eq | (32'h1 << (`TDR_DATA_EN_LO + b)));
            ev('0, adrs[0], dmv ^ ~lane[b], 1'h1);
            ev('0, adrs[0], dmv ^ lane[b], 1'h0);
        end
        sw(`DREG_SEL_TRIGGER, g_en | c_or | eq | d_inv | (32'h1 << `TDR_DATA_EN_HI));
        ev('0, adrs[0], dmv, 1'h0);
        ev('0, adrs[0], dmv ^ 32'h0000_0001, 1'h1);
        sw(`DREG_SEL_TRIGGER, g_en | pc_en | eq);
        ev(32'h0000_1000, '0, '0, 1'h0);
        ev('0, adrs[0], '0, 1'h1);
        ev('0, adrs[0], '0, 1'h0);
        $display("data and combine test done");
    endtask : t_data
    task automatic t_irq;
        sw(`DREG_SEL_TRIGGER, g_en | c_or | pc_en);
        apb(1'h1, `APB_IRQ_CLEAR, 32'h0000_0003);
        apb(1'h1, `APB_IRQ_ENABLE, 32'h0000_0001);
        ev(32'h0000_1000, '0, '0, 1'h1);
        irq_is(1'h1);
        apb(1'h0, `APB_MATCH, '0);
        chk(rd, 32'h0000_1000);
        apb(1'h1, `APB_IRQ_CLEAR, 32'h0000_0001);
        irq_is(1'h0);
        apb(1'h1, `APB_IRQ_ENABLE, '0);
        ev(32'h0000_1000, '0, '0, 1'h1);
        irq_is(1'h0);
        apb(1'h0, `APB_IRQ_STATUS, '0);
        chk(rd & 32'h0000_0001, 32'h0000_0001);
        apb(1'h0, 12'h0FC, '0);
        chk({31'h0, er}, 32'h0000_0001);
        $display("irq test done");
    endtask : t_irq
    task automatic give_verdict;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #1000000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, sup_wr, pc_valid, bus_valid} = '0;
        paddr = '0;
        pwdata = '0;
        sup_sel = '0;
        sup_data = '0;
        pc = '0;
        bus_addr = '0;
        bus_data = '0;
        dmv = 32'h1122_3344;
        presetn = 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        t_pc();
        t_addr();
        t_data();
        t_irq();
        give_verdict();
    end
endmodule : level1_breakpoint_trigger_tb_top
